// file: verilog/rcl_pkg.sv
// shared constants for the riser codec link logic
package rcl_pkg;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 2;
    // nominal rates, in hertz
    localparam longint CLOCK_HZ = 64'h0000_0000_0262_5A00;
    localparam longint BIT_CLOCK_HZ = 64'h0000_0000_00BB_8000;
    localparam int NCO_W = 16;
    // phase step so the accumulator's top bit runs at the bit clock rate
    localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(
        (BIT_CLOCK_HZ * 64'h0000_0000_0001_0000 + CLOCK_HZ / 2) / CLOCK_HZ);
    localparam logic [NCO_W-1:0] NCO_RESET = 16'h0000;
    // codec addresses: primary sits at zero, demoted codecs at the next one
    localparam logic [1:0] ADDR_PRIMARY = 2'h0;
    localparam logic [1:0] ADDR_DEMOTED = 2'h1;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_BUSY = 2'b10
    } rcl_tx_e;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b01,
        LK_SHIFT = 2'b10
    } rcl_link_e;
endpackage : rcl_pkg

// file: verilog/rcl_riser_codec_link.sv
// riser codec link logic: role select, bit clock source, serial slots, fifo
// Notes on behaviour
// R1: a primary riser codec sources the bit clock, nominally 12.288 MHz.
// R2: bit clock pin is driven only while the riser holds the primary role.
// R3: controller drives a frame sync pulse, about 1.3 us, to all codecs.
// R4: controller drives one outbound serial line that every codec receives.
// R5: only the primary codec drives the first inbound serial line.
// R6: the second inbound line carries data from a primary or secondary codec.
// R7: controller holds active-low link reset; all codecs obey it.
// R8: codec select low means the onboard primary codec owns the link.
// R9: select low demotes riser codecs to next address and next inbound line.
// R10: select high lets a riser primary take over; motherboard disables codecs.
// R11: at most one primary codec drives the link at any time.
// R12: behaviour is the same whichever controller masters the link.
// R13: inputs come from the motherboard, outputs from the riser.
// R14: over-current is reported to the motherboard on an active-low flag.
// R15: role is taken from select while link reset is low, held until next.
`timescale 1ns/1ps
`default_nettype none

module rcl_fifo #(
    parameter int WIDTH = rcl_pkg::WORD_W,
    parameter int DEPTH = rcl_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
    logic [AW:0] count_ff, nxt_count;
    logic push, pop;

    always_comb begin
        inReady = (count_ff != FULL);
        outValid = (count_ff != '0);
        outData = mem[rdPtr_ff];
        push = inValid && inReady;
        pop = outValid && outReady;
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        if (push) begin
            nxt_wrPtr = (wrPtr_ff == LAST) ? '0 : wrPtr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rdPtr = (rdPtr_ff == LAST) ? '0 : rdPtr_ff + 1'b1;
        end
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
        end
    end

    // storage has no reset; words are only read once counted in
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_ff] <= inData;
        end
    end
endmodule : rcl_fifo

module rcl_riser_codec_link (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic linkBitClockIn,
    output logic linkBitClockOut,
    output logic linkBitClockOe,
    input wire logic linkFrameSync,
    input wire logic linkSerialOut,
    output logic linkSerialInFirstOut,
    output logic linkSerialInFirstOe,
    output logic linkSerialInSecondOut,
    output logic linkSerialInSecondOe,
    input wire logic linkResetN,
    input wire logic onboardCodecSelectN,
    input wire logic usbOvercurrentDetect,
    output logic usbOvercurrentN,
    output logic riserPrimary,
    output logic [1:0] codecAddress,
    input wire logic [rcl_pkg::WORD_W-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [rcl_pkg::WORD_W-1:0] rxData,
    output logic rxValid
);
    localparam int W = rcl_pkg::WORD_W;
    localparam logic [3:0] LAST_BIT = 4'(W - 1);

    // main clock domain
    logic [1:0] rstSync, selSync, usbSync, ackSync, rxTogSync;
    logic [W-1:0] fifoData;
    logic fifoValid, fifoReady;
    rcl_pkg::rcl_tx_e txState_ff, nxt_txState;
    logic [W-1:0] txHold_ff, nxt_txHold;
    logic txReq_ff, nxt_txReq;
    logic riserPrimary_ff, nxt_riserPrimary;
    logic [1:0] codecAddress_ff, nxt_codecAddress;
    logic usbOvercurrentN_ff, nxt_usbOvercurrentN;
    logic [rcl_pkg::NCO_W-1:0] nco_ff, nxt_nco;
    logic bitClockOut_ff, nxt_bitClockOut;
    logic rxSeen_ff, nxt_rxSeen;
    logic [W-1:0] rxData_ff, nxt_rxData;
    logic rxValid_ff, nxt_rxValid;

    // link-domain state that the main domain reads through crossings
    logic ackTog_ff, rxTog_ff;
    logic [W-1:0] rxHold_ff;

    rcl_fifo #(.WIDTH(W), .DEPTH(rcl_pkg::FIFO_DEPTH)) u_rcl_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .inData(txData),
        .inValid(txValid),
        .inReady(txReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoReady)
    );

    // pins and link-domain toggles reach logic only after two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'h0;
            selSync <= 2'h0;
            usbSync <= 2'h0;
            ackSync <= 2'h0;
            rxTogSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], linkResetN};
            selSync <= {selSync[0], onboardCodecSelectN};
            usbSync <= {usbSync[0], usbOvercurrentDetect};
            ackSync <= {ackSync[0], ackTog_ff};
            rxTogSync <= {rxTogSync[0], rxTog_ff};
        end
    end

    always_comb begin
        nxt_riserPrimary = riserPrimary_ff;
        nxt_codecAddress = codecAddress_ff;
        // role follows select only while the link is in reset
        if (!rstSync[1]) begin // R15
            nxt_riserPrimary = selSync[1]; // R8 R10
            nxt_codecAddress = selSync[1] ? rcl_pkg::ADDR_PRIMARY
                                          : rcl_pkg::ADDR_DEMOTED; // R9
        end
        nxt_usbOvercurrentN = !usbSync[1]; // R14
        // fractional divider: average rate is nominal, edges jitter by a cycle
        nxt_nco = nco_ff + rcl_pkg::NCO_STEP; // R1
        nxt_bitClockOut = nco_ff[rcl_pkg::NCO_W-1];
        fifoReady = (txState_ff == rcl_pkg::TX_IDLE);
        nxt_txState = txState_ff;
        nxt_txHold = txHold_ff;
        nxt_txReq = txReq_ff;
        unique case (txState_ff)
            rcl_pkg::TX_IDLE: begin
                if (fifoValid) begin
                    nxt_txHold = fifoData;
                    nxt_txReq = !txReq_ff;
                    nxt_txState = rcl_pkg::TX_BUSY;
                end
            end
            rcl_pkg::TX_BUSY: begin
                // hold word stable until the link domain has taken it
                if (ackSync[1] == txReq_ff) begin
                    nxt_txState = rcl_pkg::TX_IDLE;
                end
            end
            default: begin
                nxt_txState = rcl_pkg::TX_IDLE;
            end
        endcase
        nxt_rxSeen = rxSeen_ff;
        nxt_rxData = rxData_ff;
        nxt_rxValid = 1'b0;
        if (rxTogSync[1] != rxSeen_ff) begin
            nxt_rxSeen = rxTogSync[1];
            nxt_rxData = rxHold_ff;
            nxt_rxValid = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            riserPrimary_ff <= 1'b0;
            codecAddress_ff <= rcl_pkg::ADDR_DEMOTED;
            usbOvercurrentN_ff <= 1'b1;
            nco_ff <= rcl_pkg::NCO_RESET;
            bitClockOut_ff <= 1'b0;
            txState_ff <= rcl_pkg::TX_IDLE;
            txHold_ff <= rcl_pkg::WORD_RESET;
            txReq_ff <= 1'b0;
            rxSeen_ff <= 1'b0;
            rxData_ff <= rcl_pkg::WORD_RESET;
            rxValid_ff <= 1'b0;
        end else begin
            riserPrimary_ff <= nxt_riserPrimary;
            codecAddress_ff <= nxt_codecAddress;
            usbOvercurrentN_ff <= nxt_usbOvercurrentN;
            nco_ff <= nxt_nco;
            bitClockOut_ff <= nxt_bitClockOut;
            txState_ff <= nxt_txState;
            txHold_ff <= nxt_txHold;
            txReq_ff <= nxt_txReq;
            rxSeen_ff <= nxt_rxSeen;
            rxData_ff <= nxt_rxData;
            rxValid_ff <= nxt_rxValid;
        end
    end

    assign riserPrimary = riserPrimary_ff;
    assign codecAddress = codecAddress_ff;
    assign usbOvercurrentN = usbOvercurrentN_ff;
    assign linkBitClockOut = bitClockOut_ff;
    assign linkBitClockOe = riserPrimary_ff; // R2
    assign rxData = rxData_ff;
    assign rxValid = rxValid_ff;

    a_role_latch: assert property (@(posedge clock) disable iff (!rst_b)
        (!rstSync[1] && selSync[1]) |=> riserPrimary_ff) // R15
        else $error("role not taken from select during link reset");
    a_role_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (rstSync[1] && $past(rstSync[1])) |-> $stable(riserPrimary_ff)) // R15
        else $error("role changed outside link reset");
    a_clock_drive: assert property (@(posedge clock) disable iff (!rst_b)
        (!rstSync[1] && !selSync[1]) |=> !linkBitClockOe) // R2
        else $error("bit clock driven while onboard codec owns link");
    a_demote_addr: assert property (@(posedge clock) disable iff (!rst_b)
        !riserPrimary_ff |-> codecAddress_ff == rcl_pkg::ADDR_DEMOTED) // R9
        else $error("demoted codec not on next address");
    a_overcurrent: assert property (@(posedge clock) disable iff (!rst_b)
        usbSync[1] |=> !usbOvercurrentN) // R14
        else $error("over-current not flagged low");

    // link clock domain
    logic [1:0] lkRstSync, lkPrimSync, lkReqSync;
    rcl_pkg::rcl_link_e lkState_ff, nxt_lkState;
    logic syncPrev_ff, nxt_syncPrev;
    logic [3:0] bitCnt_ff, nxt_bitCnt;
    logic [W-1:0] txShift_ff, nxt_txShift;
    logic [W-1:0] rxShift_ff, nxt_rxShift;
    logic [W-1:0] nxt_rxHold;
    logic nxt_rxTog, nxt_ackTog;
    logic reqSeen_ff, nxt_reqSeen;
    logic pending_ff, nxt_pending;
    logic serialBit_ff, nxt_serialBit;
    logic firstOe_ff, nxt_firstOe;
    logic secondOe_ff, nxt_secondOe;
    logic linkUp, frameEdge;

    always_ff @(posedge linkBitClockIn or negedge rst_b) begin
        if (!rst_b) begin
            lkRstSync <= 2'h0;
            lkPrimSync <= 2'h0;
            lkReqSync <= 2'h0;
        end else begin
            lkRstSync <= {lkRstSync[0], linkResetN};
            lkPrimSync <= {lkPrimSync[0], riserPrimary_ff};
            lkReqSync <= {lkReqSync[0], txReq_ff};
        end
    end

    always_comb begin
        // same framing whichever controller masters the link
        linkUp = lkRstSync[1]; // R7 R12
        frameEdge = linkFrameSync && !syncPrev_ff; // R3
        nxt_syncPrev = linkFrameSync;
        nxt_lkState = lkState_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_txShift = txShift_ff;
        nxt_rxShift = rxShift_ff;
        nxt_rxHold = rxHold_ff;
        nxt_rxTog = rxTog_ff;
        nxt_ackTog = ackTog_ff;
        nxt_reqSeen = reqSeen_ff;
        nxt_pending = pending_ff;
        nxt_serialBit = 1'b0;
        if (lkReqSync[1] != reqSeen_ff) begin
            nxt_reqSeen = lkReqSync[1];
            nxt_pending = 1'b1;
        end
        unique case (lkState_ff)
            rcl_pkg::LK_IDLE: begin
                if (linkUp && frameEdge) begin
                    nxt_lkState = rcl_pkg::LK_SHIFT;
                    nxt_bitCnt = rcl_pkg::BIT_CNT_RESET;
                    // an empty slot is sent as zeros
                    nxt_txShift = pending_ff ? txHold_ff : rcl_pkg::WORD_RESET;
                    if (pending_ff) begin
                        nxt_pending = 1'b0;
                        nxt_ackTog = !ackTog_ff;
                    end
                end
            end
            rcl_pkg::LK_SHIFT: begin
                nxt_serialBit = txShift_ff[W-1];
                nxt_txShift = {txShift_ff[W-2:0], 1'b0};
                nxt_rxShift = {rxShift_ff[W-2:0], linkSerialOut}; // R4
                nxt_bitCnt = bitCnt_ff + 1'b1;
                if (bitCnt_ff == LAST_BIT) begin
                    nxt_lkState = rcl_pkg::LK_IDLE;
                    nxt_rxHold = {rxShift_ff[W-2:0], linkSerialOut};
                    nxt_rxTog = !rxTog_ff;
                end
                if (!linkUp) begin
                    nxt_lkState = rcl_pkg::LK_IDLE;
                end
            end
            default: begin
                nxt_lkState = rcl_pkg::LK_IDLE;
            end
        endcase
        // while the link is up, exactly one inbound line is driven, chosen by role; none while it is down
        nxt_firstOe = linkUp && lkPrimSync[1]; // R5 R11
        nxt_secondOe = linkUp && !lkPrimSync[1]; // R6 R9 R11
    end

    always_ff @(posedge linkBitClockIn or negedge rst_b) begin
        if (!rst_b) begin
            lkState_ff <= rcl_pkg::LK_IDLE;
            syncPrev_ff <= 1'b0;
            bitCnt_ff <= rcl_pkg::BIT_CNT_RESET;
            txShift_ff <= rcl_pkg::WORD_RESET;
            rxShift_ff <= rcl_pkg::WORD_RESET;
            rxHold_ff <= rcl_pkg::WORD_RESET;
            rxTog_ff <= 1'b0;
            ackTog_ff <= 1'b0;
            reqSeen_ff <= 1'b0;
            pending_ff <= 1'b0;
            serialBit_ff <= 1'b0;
            firstOe_ff <= 1'b0;
            secondOe_ff <= 1'b0;
        end else begin
            lkState_ff <= nxt_lkState;
            syncPrev_ff <= nxt_syncPrev;
            bitCnt_ff <= nxt_bitCnt;
            txShift_ff <= nxt_txShift;
            rxShift_ff <= nxt_rxShift;
            rxHold_ff <= nxt_rxHold;
            rxTog_ff <= nxt_rxTog;
            ackTog_ff <= nxt_ackTog;
            reqSeen_ff <= nxt_reqSeen;
            pending_ff <= nxt_pending;
            serialBit_ff <= nxt_serialBit;
            firstOe_ff <= nxt_firstOe;
            secondOe_ff <= nxt_secondOe;
        end
    end

    assign linkSerialInFirstOut = serialBit_ff;
    assign linkSerialInFirstOe = firstOe_ff;
    assign linkSerialInSecondOut = serialBit_ff;
    assign linkSerialInSecondOe = secondOe_ff;

    a_first_line: assert property (@(posedge linkBitClockIn)
        disable iff (!rst_b)
        linkSerialInFirstOe |-> $past(lkPrimSync[1])) // R5
        else $error("first inbound line driven by demoted codec");
    a_second_line: assert property (@(posedge linkBitClockIn)
        disable iff (!rst_b)
        (linkUp && !lkPrimSync[1]) |=> linkSerialInSecondOe) // R9
        else $error("demoted codec not on second inbound line");
    a_one_driver: assert property (@(posedge linkBitClockIn)
        disable iff (!rst_b)
        !(linkSerialInFirstOe && linkSerialInSecondOe)) // R11
        else $error("both inbound lines driven at once");
    a_slot_length: assert property (@(posedge linkBitClockIn)
        disable iff (!rst_b)
        (lkState_ff == rcl_pkg::LK_IDLE && linkUp && frameEdge)
        |=> (lkState_ff == rcl_pkg::LK_SHIFT || !linkUp)[*8]) // R1
        else $error("slot shorter than expected");
endmodule : rcl_riser_codec_link

`default_nettype wire

// file: dv/rcl_codec_partner.sv
// link controller and motherboard codec model for the riser link bench
`timescale 1ns/1ps
`default_nettype none
module rcl_codec_partner (
    input wire logic bitClk,
    input wire logic inFirst,
    input wire logic inSecond,
    output var logic ownClk,
    output var logic frameSync,
    output var logic serialOut,
    output var logic resetN,
    output var logic selectN,
    output var logic mbPattern
);
    logic runClk = 1'b0;
    initial begin
        ownClk = 1'b0;
        frameSync = 1'b0;
        serialOut = 1'b0;
        resetN = 1'b0;
        selectN = 1'b0;
        mbPattern = 1'b0;
    end
    // onboard codec clocks the link only while primary, and only during link reset and frames
    always #80 ownClk = (runClk && !selectN) ? ~ownClk : 1'b0;
    // undriven inbound lines must not hold their last value
    always #40 mbPattern = ~mbPattern;
    task automatic linkReset(input logic sel);
        resetN = 1'b0;
        selectN = sel;
        runClk = 1'b1;
        #1000;
        resetN = 1'b1;
        #1000;
        runClk = 1'b0;
    endtask : linkReset
    task automatic frame(input logic [15:0] word, input int syncLen,
            output logic [15:0] gotFirst, output logic [15:0] gotSecond);
        runClk = 1'b1;
        // a stopped clock needs a few edges to carry a queued word across
        repeat (4) @(posedge bitClk);
        @(posedge bitClk);
        #1 frameSync = 1'b1;
        for (int i = 0; i < 17; i++) begin
            @(posedge bitClk);
            #1;
            frameSync = (i + 1 < syncLen);
            serialOut = (i < 16) ? word[15-i] : 1'b0;
            @(negedge bitClk);
            if (i > 0) begin
                gotFirst = {gotFirst[14:0], inFirst};
                gotSecond = {gotSecond[14:0], inSecond};
            end
        end
        repeat (4) @(posedge bitClk);
        runClk = 1'b0;
    endtask : frame
endmodule : rcl_codec_partner
`default_nettype wire

// file: dv/tb_riser_codec_link_select.sv
// self-checking bench for the riser codec link logic
`timescale 1ns/1ps
`default_nettype none
module tb_riser_codec_link_select;
    logic clock, rst_b, usbOvercurrentDetect, txValid, txReady, rxValid;
    logic [15:0] txData, rxData, lastRx;
    logic bitOut, bitOe, firstOut, firstOe, secondOut, secondOe;
    logic ownClk, frameSync, serialOut, resetN, selectN, mbPattern;
    logic usbOvercurrentN, riserPrimary;
    logic [1:0] codecAddress;
    wire logic bitWire, firstWire, secondWire;
    int errCount = 0;
    int comparisons = 0;
    int rxCount = 0;
    assign bitWire = bitOe ? bitOut : ownClk;
    assign firstWire = firstOe ? firstOut : mbPattern;
    assign secondWire = secondOe ? secondOut : mbPattern;
    rcl_riser_codec_link u_rcl_riser_codec_link (.clock(clock),
        .rst_b(rst_b), .linkBitClockIn(bitWire), .linkBitClockOut(bitOut),
        .linkBitClockOe(bitOe), .linkFrameSync(frameSync),
        .linkSerialOut(serialOut), .linkSerialInFirstOut(firstOut),
        .linkSerialInFirstOe(firstOe), .linkSerialInSecondOut(secondOut),
        .linkSerialInSecondOe(secondOe), .linkResetN(resetN),
        .onboardCodecSelectN(selectN),
        .usbOvercurrentDetect(usbOvercurrentDetect),
        .usbOvercurrentN(usbOvercurrentN), .riserPrimary(riserPrimary),
        .codecAddress(codecAddress), .txData(txData), .txValid(txValid),
        .txReady(txReady), .rxData(rxData), .rxValid(rxValid));
    rcl_codec_partner u_rcl_codec_partner (.bitClk(bitWire),
        .inFirst(firstWire), .inSecond(secondWire), .ownClk(ownClk),
        .frameSync(frameSync), .serialOut(serialOut), .resetN(resetN),
        .selectN(selectN), .mbPattern(mbPattern));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rxValid === 1'b1) begin
            lastRx <= rxData;
            rxCount <= rxCount + 1;
        end
    end
    task automatic end_of_test;
        $display("compared %0d, mismatched %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    task automatic settle;
        @(posedge clock);
        #2;
    endtask : settle
    task automatic push(input logic [15:0] word);
        txData = word;
        txValid = 1'b1;
        settle();
        txValid = 1'b0;
        settle();
    endtask : push
    task automatic runFrame(input logic [15:0] word, input int syncLen,
            input logic primary);
        logic [15:0] gotF, gotS;
        int c0;
        c0 = rxCount;
        #500;
        u_rcl_codec_partner.frame(~word, syncLen, gotF, gotS);
        check(primary ? gotF : gotS, word);
        check({firstOe, secondOe}, primary ? 2'b10 : 2'b01);
        for (int i = 0; i < 40 && rxCount == c0; i++) settle();
        check(lastRx, ~word);
        settle();
    endtask : runFrame
    task automatic testReset;
        check({bitOe, firstOe, secondOe, rxValid}, 4'h0);
        check({usbOvercurrentN, riserPrimary, codecAddress}, 4'h9);
        check(txReady, 1'b1);
    endtask : testReset
    task automatic testDemoted;
        u_rcl_codec_partner.linkReset(1'b0);
        settle();
        check({riserPrimary, codecAddress, bitOe}, 4'h2);
        push(16'hA5C3);
        runFrame(16'hA5C3, 16, 1'b0);
        runFrame(16'h0000, 16, 1'b0);
        u_rcl_codec_partner.selectN = 1'b1;
        repeat (10) settle();
        check(riserPrimary, 1'b0);
    endtask : testDemoted
    task automatic testPrimary;
        int n;
        logic prev;
        u_rcl_codec_partner.linkReset(1'b1);
        settle();
        check({riserPrimary, codecAddress, bitOe}, 4'h9);
        n = 0;
        prev = bitOut;
        repeat (100) begin
            settle();
            if (bitOut && !prev) n++;
            prev = bitOut;
        end
        check(n == 30 || n == 31, 1'b1);
        push(16'h5A3C);
        runFrame(16'h5A3C, 1, 1'b1);
    endtask : testPrimary
    task automatic testFifo;
        int n;
        n = 0;
        while (txReady === 1'b1 && n < 12) begin
            push(16'h1000 + 16'(n));
            n++;
        end
        check(n >= 8, 1'b1);
        check(txReady, 1'b0);
        for (int i = 0; i < n; i++) runFrame(16'h1000 + 16'(i), 16, 1'b1);
        runFrame(16'h0000, 16, 1'b1);
    endtask : testFifo
    task automatic testOvercurrent;
        usbOvercurrentDetect = 1'b1;
        repeat (2) settle();
        check(usbOvercurrentN, 1'b1);
        settle();
        check(usbOvercurrentN, 1'b0);
        usbOvercurrentDetect = 1'b0;
        repeat (3) settle();
        check(usbOvercurrentN, 1'b1);
    endtask : testOvercurrent
    initial begin
        #400000;
        errCount++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        usbOvercurrentDetect = 1'b0;
        txValid = 1'b0;
        txData = 16'h0000;
        repeat (4) @(posedge clock);
        #2 rst_b = 1'b1;
        testReset();
        testDemoted();
        testPrimary();
        testFifo();
        testOvercurrent();
        end_of_test();
    end
endmodule : tb_riser_codec_link_select
`default_nettype wire
